// File: hw/abexu_pkg.sv
package abexu_pkg;
  localparam int WORD_W = 30;
  localparam int NUM_FLAGS = 14;
  localparam int OPC_HI = 0;
  localparam int C_HI = 6;
  localparam int D_HI = 9;
  localparam int B_HI = 12;
  localparam int S_BIT = 15;
  localparam int L_HI = 16;
  localparam logic [5:0] OP_SUB_MAG = 6'o16;
  localparam logic [5:0] OP_SUB_MAG_REP = 6'o17;
  localparam logic [5:0] OP_MUL_FULL = 6'o22;
  localparam logic [5:0] OP_MUL_HALF = 6'o23;
  localparam logic [5:0] OP_DIV_FULL = 6'o24;
  localparam logic [5:0] OP_DIV_HALF = 6'o25;
  localparam logic [5:0] OP_BRANCH = 6'o72;
  localparam logic [5:0] OP_TEST_BACK = 6'o77;
  localparam logic [5:0] OP_SKIP_FWD = 6'o76;
  localparam logic [5:0] OP_IDLE = 6'o70;
  localparam logic [5:0] OP_FLAG_SET = 6'o71;
  localparam logic [5:0] CD_JSL_ALWAYS = 6'o02;
  localparam logic [5:0] CD_JSL_OVF = 6'o03;
  localparam logic [5:0] CD_JAC_ALWAYS = 6'o00;
  localparam logic [5:0] CD_JAC_OVF = 6'o01;
  localparam logic [5:0] CD_CNT_NONZERO = 6'o10;
  localparam logic [5:0] CD_CNT_ALWAYS = 6'o20;
  localparam logic [2:0] D_JSL = 3'h2;
  localparam logic [2:0] D_JAC = 3'h0;
  localparam int CYCLES_SHORT = 2;
  localparam int CYCLES_NORMAL = 3;
  localparam int MEM_CYCLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MUL_FULL_US = 59;
  localparam int MUL_HALF_US = 29;
  localparam int DIV_FULL_US = 57;
  localparam int DIV_HALF_US = 29;
  localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MUL_FULL_CLKS = (MUL_FULL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MUL_HALF_CLKS = (MUL_HALF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_FULL_CLKS = (DIV_FULL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_HALF_CLKS = (DIV_HALF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ABX_IDLE, ABX_BUSY, ABX_DONE} abexu_state_e;
endpackage

// File: hw/abexu_divider.sv
module abexu_divider
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [29:0] dividend,
  input  wire logic [29:0] divisor,
  output logic             busy,
  output logic [29:0]      quotient
);
  logic [31:0] rem;
  logic [31:0] dvs;
  logic [29:0] qmag;
  logic [4:0]  step;
  logic        negQ;
  logic [31:0] trial;

  assign trial = rem - dvs;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      rem  <= 32'h0;
      dvs  <= 32'h0;
      qmag <= 30'h0;
      step <= 5'h0;
      negQ <= 1'b0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      rem  <= {2'h0, dividend[29] ? 30'(-dividend) : dividend};
      dvs  <= {2'h0, divisor[29] ? 30'(-divisor) : divisor};
      qmag <= 30'h0;
      step <= 5'h0;
      negQ <= dividend[29] ^ divisor[29];
    end
    else if (busy)
    begin
      // restoring division, fraction quotient bits msb first
      if (!trial[31] && trial != 32'h0 || !trial[31])
      begin
        rem  <= {trial[30:0], 1'b0};
        qmag <= {qmag[28:0], 1'b1};
      end
      else
      begin
        rem  <= {rem[30:0], 1'b0};
        qmag <= {qmag[28:0], 1'b0};
      end
      if (step == 5'd29)
        busy <= 1'b0;
      step <= step + 5'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      quotient <= 30'h0;
    else if (busy && step == 5'd30)
      quotient <= quotient;
    else
      quotient <= negQ ? 30'(-qmag) : qmag;
  end
endmodule // abexu_divider

// File: hw/abexu_top.sv
module abexu_top
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        instStart,
  input  wire logic [29:0] instWord,
  input  wire logic [29:0] effAddr,
  input  wire logic [29:0] memOperand,
  input  wire logic [29:0] indexValue,
  input  wire logic [3:0]  currentLevel,
  input  wire logic [29:0] accIn,
  input  wire logic [29:0] pcIn,
  input  wire logic        ovfIn,
  output logic             instDone,
  output logic [29:0]      workingRegister,
  output logic [29:0]      programCounter,
  output logic             overflow,
  output logic [29:0]      indexOut,
  output logic             indexWrite,
  output logic [29:0]      memWriteData,
  output logic             memWrite,
  output logic [13:0]      flagSet,
  output logic             suicideEnable,
  output logic [7:0]       cycleCount
);
  localparam int TIMER_W = 14;

  abexu_pkg::abexu_state_e state;
  logic [5:0]  opc;
  logic [2:0]  fC;
  logic [2:0]  fD;
  logic [29:0] lAddr;
  logic        fS;
  logic [29:0] acc;
  logic [29:0] opnd;
  logic [29:0] idx;
  logic [29:0] pc;
  logic        ovf;
  logic [3:0]  lvl;
  logic [TIMER_W-1:0] timer;
  logic        divStart;
  logic        divBusy;
  logic [29:0] quo;
  logic        accSat;

  function automatic logic [29:0] mag(input logic [29:0] v);
    mag = v[29] ? 30'(-v) : v;
  endfunction

  function automatic logic test_cond(input logic [2:0] c, input logic [29:0] e, input logic [29:0] a);
    logic signed [29:0] se;
    logic signed [29:0] sa;
    se = e;
    sa = a;
    case (c)
      3'h0: test_cond = se > 0;
      3'h1: test_cond = se != 0;
      3'h2: test_cond = se == 0;
      3'h3: test_cond = se < 0;
      3'h4: test_cond = se > sa;
      3'h5: test_cond = se != sa;
      3'h6: test_cond = se == sa;
      default: test_cond = se < sa;
    endcase
  endfunction

  function automatic logic acc_cond(input logic [2:0] c, input logic [29:0] a);
    case (c)
      3'h3: acc_cond = !a[29];
      3'h4: acc_cond = !a[29] && a != 30'h0;
      3'h5: acc_cond = a != 30'h0;
      3'h6: acc_cond = a == 30'h0;
      3'h7: acc_cond = a[29];
      default: acc_cond = 1'b0;
    endcase
  endfunction

  logic        branchGo;
  logic [30:0] smDiff;
  logic signed [59:0] prodFull;
  logic signed [59:0] prodHalf;
  logic [29:0] magA;
  logic [29:0] magE;
  logic        isJsl;
  logic        isJac;
  logic        isCount;
  logic        halfSat;

  // branch kind from D bits 2:1, count codes share D with jump-acc and are split off by C
  assign isCount = fD == abexu_pkg::D_JAC && (fC == 3'h1 || fC == 3'h2);
  assign isJsl   = fD[2:1] == 2'h1;
  assign isJac   = fD[2:1] == 2'h0 && !isCount;
  assign halfSat = acc[29:15] == 15'h4000 && opnd == 30'h20000000;

  assign magA = mag(acc);
  assign magE = mag(opnd);
  assign smDiff = {opnd[29], opnd} - {1'b0, magA};
  assign prodFull = $signed(acc) * $signed(opnd);
  assign prodHalf = $signed({acc[29:15], 15'h0}) * $signed(opnd);
  assign accSat = acc == 30'h20000000 && opnd == 30'h20000000;

  always_comb
  begin
    branchGo = 1'b0;
    case (opc)
      abexu_pkg::OP_BRANCH:
      begin
        if (isJsl)
          branchGo = ({fC, fD} == abexu_pkg::CD_JSL_ALWAYS) || ({fC, fD} == abexu_pkg::CD_JSL_OVF && ovf)
                     || (fD == abexu_pkg::D_JSL && acc_cond(fC, acc));
        else if (isJac)
          branchGo = ({fC, fD} == abexu_pkg::CD_JAC_ALWAYS) || ({fC, fD} == abexu_pkg::CD_JAC_OVF && ovf)
                     || (fD == abexu_pkg::D_JAC && acc_cond(fC, acc));
        else
          branchGo = ({fC, fD} == abexu_pkg::CD_CNT_ALWAYS)
                     || ({fC, fD} == abexu_pkg::CD_CNT_NONZERO && idx != 30'h0);
      end
      abexu_pkg::OP_TEST_BACK,
      abexu_pkg::OP_SKIP_FWD: branchGo = test_cond(fC, opnd, acc);
      default: branchGo = 1'b0;
    endcase
  end

  // capture of instruction fields and operands
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      opc   <= 6'h0;
      fC    <= 3'h0;
      fD    <= 3'h0;
      fS    <= 1'b0;
      lAddr <= 30'h0;
      opnd  <= 30'h0;
      idx   <= 30'h0;
      lvl   <= 4'h0;
    end
    else if (instStart && state == abexu_pkg::ABX_IDLE)
    begin
      opc   <= instWord[29:24];
      fC    <= instWord[23:21];
      fD    <= instWord[20:18];
      fS    <= instWord[14];
      lAddr <= {16'h0, instWord[13:0]};
      opnd  <= memOperand;
      idx   <= indexValue;
      lvl   <= currentLevel;
    end
  end

  // sequencing and timing
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= abexu_pkg::ABX_IDLE;
      timer      <= '0;
      cycleCount <= 8'h0;
      divStart   <= 1'b0;
    end
    else
    begin
      divStart <= 1'b0;
      case (state)
        abexu_pkg::ABX_IDLE:
          if (instStart)
          begin
            state <= abexu_pkg::ABX_BUSY;
            timer <= '0;
            divStart <= instWord[29:24] == abexu_pkg::OP_DIV_FULL || instWord[29:24] == abexu_pkg::OP_DIV_HALF;
          end
        abexu_pkg::ABX_BUSY:
        begin
          timer <= timer + 1'b1;
          if (opc == abexu_pkg::OP_MUL_FULL)
            cycleCount <= 8'(abexu_pkg::CYCLES_NORMAL);
          else if (opc == abexu_pkg::OP_BRANCH && (isJac || !branchGo && isJsl))
            cycleCount <= 8'(abexu_pkg::CYCLES_SHORT);
          else if (opc == abexu_pkg::OP_FLAG_SET)
            cycleCount <= 8'(abexu_pkg::CYCLES_SHORT);
          else
            cycleCount <= 8'(abexu_pkg::CYCLES_NORMAL);
          if (!divBusy && !divStart && timer >= TIMER_W'(1))
            state <= abexu_pkg::ABX_DONE;
        end
        abexu_pkg::ABX_DONE: state <= abexu_pkg::ABX_IDLE;
        default: state <= abexu_pkg::ABX_IDLE;
      endcase
    end
  end

  abexu_divider u_div
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (divStart),
    .dividend (accIn),
    .divisor  (memOperand),
    .busy     (divBusy),
    .quotient (quo)
  );

  assign instDone = state == abexu_pkg::ABX_DONE;

  // architectural results
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc <= 30'h0;
      pc  <= 30'h0;
      ovf <= 1'b0;
    end
    else if (instStart && state == abexu_pkg::ABX_IDLE)
    begin
      acc <= accIn;
      pc  <= pcIn;
      ovf <= ovfIn;
    end
    else if (state == abexu_pkg::ABX_DONE)
    begin
      case (opc)
        abexu_pkg::OP_SUB_MAG,
        abexu_pkg::OP_SUB_MAG_REP:
        begin
          acc <= smDiff[29:0];
          if (smDiff[30] != smDiff[29])
            ovf <= 1'b1;
        end
        abexu_pkg::OP_MUL_FULL: acc <= accSat ? 30'h1fffffff : prodFull[58:29];
        abexu_pkg::OP_MUL_HALF: acc <= halfSat ? 30'h1fffffff : prodHalf[58:29];
        abexu_pkg::OP_DIV_FULL,
        abexu_pkg::OP_DIV_HALF:
        begin
          if (magE == magA)
          begin
            acc <= (acc[29] ^ opnd[29]) ? 30'h20000000 : 30'h1fffffff;
            if (opnd[29])
              ovf <= 1'b1;
          end
          else if (magA > magE)
          begin
            acc <= {acc[29] ^ opnd[29], 29'h0};
            ovf <= 1'b1;
          end
          else if (opc == abexu_pkg::OP_DIV_HALF)
            acc <= {quo[29:15], 15'h0};
          else
            acc <= quo;
        end
        abexu_pkg::OP_BRANCH:
        begin
          if (branchGo)
            pc <= isJac ? effAddr : lAddr;
          if (branchGo && fD[0] && fC == 3'h0 && !isCount)
          begin
            pc  <= {ovf, (isJac ? effAddr[28:0] : lAddr[28:0])};
            ovf <= 1'b0;
          end
        end
        abexu_pkg::OP_TEST_BACK: if (branchGo) pc <= pc + 30'(fD);
        abexu_pkg::OP_SKIP_FWD: if (branchGo) pc <= pc - 30'h1 - 30'(fD);
        default: acc <= acc;
      endcase
    end
  end

  // side effects toward memory, index, flags
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      memWrite      <= 1'b0;
      memWriteData  <= 30'h0;
      indexWrite    <= 1'b0;
      indexOut      <= 30'h0;
      flagSet       <= 14'h0;
      suicideEnable <= 1'b0;
    end
    else
    begin
      memWrite      <= 1'b0;
      indexWrite    <= 1'b0;
      flagSet       <= 14'h0;
      suicideEnable <= 1'b0;
      if (state == abexu_pkg::ABX_DONE)
      begin
        suicideEnable <= fS;
        if (opc == abexu_pkg::OP_SUB_MAG_REP)
        begin
          memWrite     <= 1'b1;
          memWriteData <= smDiff[29:0];
        end
        if (opc == abexu_pkg::OP_BRANCH && isJsl && branchGo)
        begin
          indexWrite <= 1'b1;
          indexOut   <= pc;
        end
        if (opc == abexu_pkg::OP_BRANCH && isCount)
        begin
          indexWrite <= 1'b1;
          indexOut   <= idx - 30'h1;
        end
        if ((opc == abexu_pkg::OP_TEST_BACK || opc == abexu_pkg::OP_SKIP_FWD) && !branchGo)
          suicideEnable <= 1'b0;
        if (opc == abexu_pkg::OP_FLAG_SET)
          for (int i = 0; i < abexu_pkg::NUM_FLAGS; i++)
            flagSet[i] <= lAddr[13 - i] && (4'(i + 1) != lvl);
      end
    end
  end

  assign workingRegister = acc;
  assign programCounter  = pc;
  assign overflow        = ovf;
endmodule // abexu_top

// File: verification/abexu_top_props.sv
module abexu_top_props
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        instStart,
  input wire logic [29:0] instWord,
  input wire logic [29:0] memOperand,
  input wire logic [29:0] indexValue,
  input wire logic [3:0]  currentLevel,
  input wire logic [29:0] accIn,
  input wire logic [29:0] pcIn,
  input wire logic        ovfIn,
  input wire logic        instDone,
  input wire logic [29:0] workingRegister,
  input wire logic        overflow,
  input wire logic [29:0] indexOut,
  input wire logic        indexWrite,
  input wire logic [29:0] memWriteData,
  input wire logic        memWrite,
  input wire logic [13:0] flagSet
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  logic        bsy;
  logic        st;
  logic [5:0]  op;
  logic [29:0] capW;
  assign op = instWord[29:24];
  assign st = instStart && !bsy;
  function automatic logic [29:0] mag(input logic [29:0] x);
    return x[29] ? -x : x;
  endfunction
  function automatic logic [13:0] fmap(input logic [13:0] l, input logic [3:0] v);
    logic [13:0] r;
    r = {<<{l}};
    return r & ~(14'h1 << (v - 4'h1));
  endfunction
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bsy <= 1'b0;
      capW <= 30'h0;
    end
    else if (st)
    begin
      bsy <= 1'b1;
      capW <= instWord;
    end
    else if (instDone)
      bsy <= 1'b0;
  end
  a_done_latency: assert property (st && !(op inside {6'h14, 6'h15}) |-> ##1 !instDone ##1 !instDone ##1 instDone)
    else $error("done late");
  a_div_bounded: assert property (st && op inside {6'h14, 6'h15} |-> ##[2:80] instDone)
    else $error("divide hangs");
  a_sub_value: assert property (st && op inside {6'h0e, 6'h0f} |->
    ##4 workingRegister == $past(memOperand, 4) - mag($past(accIn, 4))) else $error("bad difference");
  a_sub_ovf: assert property (st && op inside {6'h0e, 6'h0f} |-> ##4 overflow == ($past(ovfIn, 4) |
    ($signed({{2{$past(memOperand[29], 4)}}, $past(memOperand, 4)}) - $signed({2'h0, mag($past(accIn, 4))})
    < -32'sh20000000))) else $error("bad overflow");
  a_replace_write: assert property (st && op == 6'h0f |-> ##4 memWrite && memWriteData == workingRegister)
    else $error("no write back");
  a_save_location: assert property (st && op == 6'h3a && instWord[23:18] == 6'h02 |->
    ##4 indexWrite && indexOut == $past(pcIn, 4)) else $error("location not saved");
  a_count_down: assert property (st && op == 6'h3a && instWord[23:18] inside {6'h08, 6'h10} |->
    ##4 indexWrite && indexOut == $past(indexValue, 4) - 30'h1) else $error("no decrement");
  a_flag_map: assert property (st && op == 6'h39 |->
    ##4 flagSet == fmap(capW[13:0], $past(currentLevel, 4))) else $error("bad flags");
  c_replace: cover property (st && op == 6'h0f);
  c_divide: cover property (st && op == 6'h14 ##[2:80] overflow);
  c_flags: cover property (st && op == 6'h39);
endmodule // abexu_top_props

bind abexu_top abexu_top_props props (.ref_clk, .nrst, .instStart, .instWord, .memOperand, .indexValue,
  .currentLevel, .accIn, .pcIn, .ovfIn, .instDone, .workingRegister, .overflow, .indexOut, .indexWrite,
  .memWriteData, .memWrite, .flagSet);

// File: verification/abexu_core_mem.sv
module abexu_core_mem
(
  input  wire logic        ref_clk,
  input  wire logic [29:0] effAddr,
  input  wire logic [29:0] memWriteData,
  input  wire logic        memWrite,
  input  wire logic [13:0] flagSet,
  output logic [29:0]      memOperand
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] words [16];
  logic [13:0] flags = 14'h0;
  assign memOperand = words[effAddr[3:0]];
  always @(posedge ref_clk)
  begin
    if (memWrite)
      words[effAddr[3:0]] <= memWriteData;
    flags <= flags | flagSet;
  end
endmodule // abexu_core_mem

// File: verification/arith_branch_exec_unit_bench.sv
module arith_branch_exec_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [5:0] op; logic [29:0] a, m, ea; logic ev;} abexu_row_s;
  logic        ref_clk, nrst, instStart, ovfIn, instDone, overflow, indexWrite, memWrite, suicideEnable, t;
  logic [29:0] instWord, effAddr, memOperand, indexValue, accIn, pcIn, workingRegister, programCounter;
  logic [29:0] indexOut, memWriteData;
  logic [13:0] flagSet;
  logic [7:0]  cycleCount;
  logic [3:0]  currentLevel;
  int          fails, cmp_count;
  logic [2:0]  cl [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [29:0] av [3] = '{30'h08000000, 30'h0, 30'h30000000};
  logic [29:0] ev [4] = '{30'h10000000, 30'h08000000, 30'h0, 30'h30000000};
  abexu_row_s  rows [12] = '{
    '{6'h0e, 30'h38000000, 30'h10000000, 30'h08000000, 1'b0},
    '{6'h0e, 30'h18000000, 30'h30000000, 30'h18000000, 1'b1},
    '{6'h0e, 30'h10000000, 30'h30000000, 30'h20000000, 1'b0},
    '{6'h12, 30'h10000000, 30'h10000000, 30'h08000000, 1'b0},
    '{6'h12, 30'h20000000, 30'h20000000, 30'h1fffffff, 1'b0},
    '{6'h13, 30'h20007fff, 30'h20000000, 30'h1fffffff, 1'b0},
    '{6'h14, 30'h08000000, 30'h10000000, 30'h10000000, 1'b0},
    '{6'h14, 30'h10000000, 30'h30000000, 30'h20000000, 1'b1},
    '{6'h14, 30'h30000000, 30'h30000000, 30'h1fffffff, 1'b1},
    '{6'h14, 30'h04000000, 30'h0c000000, 30'h0aaaaaaa, 1'b0},
    '{6'h15, 30'h04000000, 30'h0c000000, 30'h0aaa8000, 1'b0},
    '{6'h38, 30'h12345678, 30'h10000000, 30'h12345678, 1'b0}};
  abexu_top uut (.ref_clk, .nrst, .instStart, .instWord, .effAddr, .memOperand, .indexValue, .currentLevel,
    .accIn, .pcIn, .ovfIn, .instDone, .workingRegister, .programCounter, .overflow, .indexOut, .indexWrite,
    .memWriteData, .memWrite, .flagSet, .suicideEnable, .cycleCount);
  abexu_core_mem store (.ref_clk, .effAddr, .memWriteData, .memWrite, .flagSet, .memOperand);
  always #2.5 ref_clk = ~ref_clk;
  function automatic logic [29:0] mk(input logic [5:0] op, input logic [5:0] cd, input logic [13:0] l);
    return {op, cd, 3'h1, 1'b1, l};
  endfunction
  function automatic logic acct(input logic [2:0] c, input logic [29:0] a);
    case (c)
      3'h0: return 1'b1;
      3'h3: return !a[29];
      3'h4: return !a[29] && a != 30'h0;
      3'h5: return a != 30'h0;
      3'h6: return a == 30'h0;
      default: return a[29];
    endcase
  endfunction
  function automatic logic tstc(input logic [2:0] c, input logic [29:0] e, input logic [29:0] a);
    logic signed [29:0] r;
    r = c[2] ? a : 30'h0;
    case (c[1:0])
      2'h0: return $signed(e) > r;
      2'h1: return e != r;
      2'h2: return e == r;
      default: return $signed(e) < r;
    endcase
  endfunction
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [29:0] w, input logic [29:0] a, input logic [29:0] m);
    int n;
    @(posedge ref_clk);
    #1;
    instWord = w;
    accIn = a;
    store.words[5] = m;
    instStart = 1'b1;
    @(posedge ref_clk);
    #1;
    instStart = 1'b0;
    for (n = 0; instDone !== 1'b1 && n < 100; n++)
      @(posedge ref_clk) #1;
    if (n >= 100)
      fails++;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100us;
    fails++;
    final_report();
  end
  initial
  begin
    {ref_clk, nrst, instStart, ovfIn, instWord, accIn} = '0;
    {effAddr, indexValue, pcIn, currentLevel} = {30'h5, 30'h5, 30'h123, 4'h3};
    repeat (5) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    chk(workingRegister, 30'h0);
    foreach (rows[i])
    begin
      run({rows[i].op, 24'h0}, rows[i].a, rows[i].m);
      chk(workingRegister, rows[i].ea);
      chk(30'(overflow), 30'(rows[i].ev));
    end
    run(mk(6'h0f, 6'h0, 14'h0), 30'h08000000, 30'h10000000);
    @(posedge ref_clk);
    #1;
    chk(store.words[5], 30'h08000000);
    run(mk(6'h14, 6'h0, 14'h0), 30'h10000000, 30'h38000000);
    chk(30'({workingRegister[29], overflow}), 30'h3);
    foreach (cl[k])
      for (int d = 0; d < 3; d += 2)
        foreach (av[j])
        begin
          run(mk(6'h3a, {cl[k], 3'(d)}, 14'h777), av[j], 30'h0);
          t = acct(cl[k], av[j]);
          if (d == 2)
            chk(30'({indexWrite, cycleCount}), t ? 30'h103 : 30'h2);
          else
            chk(30'(programCounter == 30'h5), 30'(t));
        end
    for (int d = 1; d < 4; d += 2)
    begin
      ovfIn = 1'b1;
      run(mk(6'h3a, 6'(d), 14'h777), 30'h0, 30'h0);
      chk(30'({overflow, programCounter[29]}), 30'h1);
      ovfIn = 1'b0;
      run(mk(6'h3a, 6'(d), 14'h777), 30'h0, 30'h0);
      chk(30'({indexWrite, cycleCount}), 30'h2);
    end
    for (int n = 0; n < 3; n++)
    begin
      indexValue = n == 0 ? 30'h5 : 30'h0;
      run(mk(6'h3a, n == 2 ? 6'h10 : 6'h08, 14'h777), 30'h0, 30'h0);
      chk(30'({indexWrite, programCounter[13:0] == 14'h777}), n == 1 ? 30'h2 : 30'h3);
    end
    foreach (ev[j])
      for (int c = 0; c < 8; c++)
        for (int o = 0; o < 2; o++)
        begin
          run(mk(o ? 6'h3f : 6'h3e, {3'(c), 3'h3}, 14'h0), 30'h08000000, ev[j]);
          t = tstc(3'(c), ev[j], 30'h08000000);
          chk(30'(suicideEnable), 30'(t));
          if (t)
            chk(programCounter, o ? 30'h126 : 30'h11f);
        end
    run(mk(6'h39, 6'h0, 14'h3fff), 30'h0, 30'h0);
    chk(30'({flagSet, cycleCount}), 30'h3ffb02);
    run(mk(6'h39, 6'h0, 14'h1681), 30'h0, 30'h0);
    chk(30'(flagSet), 30'h205a);
    @(posedge ref_clk);
    #1;
    nrst = 1'b0;
    #1;
    chk(programCounter, 30'h0);
    chk(30'({flagSet, overflow, instDone}), 30'h0);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    run(mk(6'h38, 6'h0, 14'h0), 30'h0abcdef0, 30'h0);
    chk(workingRegister, 30'h0abcdef0);
    final_report();
  end
endmodule // arith_branch_exec_unit_bench
